// >>> hdl/flash_host_ctrl.sv
// Purpose: host controller issuing flash command sequences and polling
// Assumes: one user order at a time, taken only while busy_o is low
// Notes:   a time-limit failure is followed by an automatic reset write; a verify mismatch is not
//
// Operation
// - host reads twice and compares toggle bit; equal means finished
// - still toggling with timeout flag: recheck, then fail and reset
// - polling always restarts from a fresh double read
// - after a time-limit failure the reset command must be written
// - host checks erase_window_bit before and after an added sector
// - writes happen only with select and strobe low, output enable high
// - each added sector load starts within 80us of the last write
`timescale 1ns/10ps
module flash_host_ctrl #(
  parameter logic [flash_host_pkg::ADDR_W-1:0] UNLOCK_A1 = 20'h00555,
  parameter logic [flash_host_pkg::ADDR_W-1:0] UNLOCK_A2 = 20'h002aa,
  parameter logic [flash_host_pkg::DATA_W-1:0] UNLOCK_D1 = 8'haa,
  parameter logic [flash_host_pkg::DATA_W-1:0] UNLOCK_D2 = 8'h55,
  parameter logic [flash_host_pkg::DATA_W-1:0] RESET_D   = 8'hf0
) (
  input  wire logic                              clk_sys_i,
  input  wire logic                              nrst_i,
  input  wire logic                              ce_i,
  input  wire logic                              cmd_valid_i,
  input  wire flash_host_pkg::op_t               cmd_i,
  input  wire logic [flash_host_pkg::ADDR_W-1:0] cmd_addr_i,
  input  wire logic [flash_host_pkg::DATA_W-1:0] cmd_data_i,
  output logic                                   busy_o,
  output logic                                   done_o,
  output logic                                   fail_o,
  output logic                                   rejected_o,
  output logic      [flash_host_pkg::DATA_W-1:0] rdata_o,
  output logic      [flash_host_pkg::DATA_W-1:0] status_o,
  input  wire logic [flash_host_pkg::DATA_W-1:0] fl_dq_i,
  output logic      [flash_host_pkg::ADDR_W-1:0] fl_addr_o,
  output logic      [flash_host_pkg::DATA_W-1:0] fl_dq_o,
  output logic                                   fl_dq_oe_o,
  output logic                                   fl_ce_n_o,
  output logic                                   fl_oe_n_o,
  output logic                                   fl_we_n_o
);
  import flash_host_pkg::*;

  localparam int SW = ADDR_W + DATA_W;

  typedef enum logic [3:0] {
    T_IDLE, T_SEQ, T_PRE, T_POST, T_P1, T_P2, T_P3, T_P4, T_VER, T_RDU,
    T_END
  } top_st_t;

  // ==========================================================
  // command sequence table
  function automatic logic [SW-1:0] seq_word(
    input op_t               op,
    input logic [2:0]        step,
    input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d
  );
    logic [SW-1:0] w;
    w = {UNLOCK_A1, RESET_D};
    if (op == OP_PROGRAM || op == OP_ERASE) begin
      unique case (step)
        3'h0:    w = {UNLOCK_A1, UNLOCK_D1};
        3'h1:    w = {UNLOCK_A2, UNLOCK_D2};
        3'h2:    w = (op == OP_PROGRAM) ? {UNLOCK_A1, CMD_PROGRAM}
                                        : {UNLOCK_A1, CMD_ERASE_SETUP};
        3'h3:    w = (op == OP_PROGRAM) ? {a, d} : {UNLOCK_A1, UNLOCK_D1};
        3'h4:    w = {UNLOCK_A2, UNLOCK_D2};
        default: w = {a, CMD_SECTOR_ERASE};
      endcase
    end else if (op == OP_ADD_SECTOR) begin
      w = {a, CMD_SECTOR_ERASE};
    end
    return w;
  endfunction

  function automatic logic [2:0] seq_last(input op_t op);
    logic [2:0] n;
    n = 3'h0;
    if (op == OP_PROGRAM) begin
      n = 3'h3;
    end else if (op == OP_ERASE) begin
      n = 3'h5;
    end
    return n;
  endfunction

  // ==========================================================
  // reset release
  logic rst_s1_r;
  logic rst_s2_r;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else if (ce_i) begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // ==========================================================
  // pin cycle engine
  flash_cyc_if cyc ();

  flash_bus_cycle u_cycle (
    .clk_i      (clk_sys_i),
    .rst_n_i    (rst_s2_r),
    .en_i       (ce_i),
    .cyc        (cyc.engine),
    .fl_dq_i    (fl_dq_i),
    .fl_addr_o  (fl_addr_o),
    .fl_dq_o    (fl_dq_o),
    .fl_dq_oe_o (fl_dq_oe_o),
    .fl_ce_n_o  (fl_ce_n_o),
    .fl_oe_n_o  (fl_oe_n_o),
    .fl_we_n_o  (fl_we_n_o)
  );

  // ==========================================================
  // operation sequencer
  top_st_t           st_r,    st_nxt;
  op_t               op_r,    op_nxt;
  logic [ADDR_W-1:0] addr_r,  addr_nxt;
  logic [DATA_W-1:0] data_r,  data_nxt;
  logic [2:0]        step_r,  step_nxt;
  logic              iss_r,   iss_nxt;
  logic              req_r,   req_nxt;
  logic              cwr_r,   cwr_nxt;
  logic [SW-1:0]     cword_r, cword_nxt;
  logic [DATA_W-1:0] first_r, first_nxt;
  logic [WIN_W-1:0]  win_r,   win_nxt;
  logic              busy_r,  busy_nxt;
  logic              done_r,  done_nxt;
  logic              fail_r,  fail_nxt;
  logic              rej_r,   rej_nxt;
  logic [DATA_W-1:0] rdat_r,  rdat_nxt;
  logic [DATA_W-1:0] stat_r,  stat_nxt;
  logic              same;

  always_comb begin
    st_nxt    = st_r;
    op_nxt    = op_r;
    addr_nxt  = addr_r;
    data_nxt  = data_r;
    step_nxt  = step_r;
    iss_nxt   = iss_r;
    req_nxt   = 1'b0;
    cwr_nxt   = cwr_r;
    cword_nxt = cword_r;
    first_nxt = first_r;
    busy_nxt  = busy_r;
    done_nxt  = 1'b0;
    fail_nxt  = fail_r;
    rej_nxt   = rej_r;
    rdat_nxt  = rdat_r;
    stat_nxt  = stat_r;
    win_nxt   = (win_r != WIN_CYC) ? WIN_W'(win_r + 1'b1) : win_r;
    same = (cyc.rdata[TOGGLE1_BIT] == first_r[TOGGLE1_BIT]);
    if (st_r == T_IDLE) begin
      if (cmd_valid_i) begin
        op_nxt   = cmd_i;
        addr_nxt = cmd_addr_i;
        data_nxt = cmd_data_i;
        step_nxt = 3'h0;
        busy_nxt = 1'b1;
        fail_nxt = 1'b0;
        rej_nxt  = 1'b0;
        unique case (cmd_i)
          OP_READ:       st_nxt = T_RDU;
          OP_POLL:       st_nxt = T_P1;
          OP_ADD_SECTOR: st_nxt = T_PRE;
          default:       st_nxt = T_SEQ;
        endcase
      end
    end else if (st_r == T_END) begin
      done_nxt = 1'b1;
      busy_nxt = 1'b0;
      st_nxt   = T_IDLE;
    end else if (!iss_r) begin
      iss_nxt   = 1'b1;
      req_nxt   = 1'b1;
      cwr_nxt   = (st_r == T_SEQ);
      cword_nxt = (st_r == T_SEQ) ? seq_word(op_r, step_r, addr_r, data_r)
                                  : {addr_r, data_r};
    end else if (cyc.ack) begin
      iss_nxt = 1'b0;
      if (st_r != T_SEQ && st_r != T_RDU && st_r != T_VER) begin
        stat_nxt = cyc.rdata;
      end
      unique case (st_r)
        T_SEQ: begin
          if (step_r != seq_last(op_r)) begin
            step_nxt = step_r + 1'b1;
          end else begin
            step_nxt = 3'h0;
            if (op_r == OP_ERASE || op_r == OP_ADD_SECTOR) begin
              win_nxt = '0;
            end
            unique case (op_r)
              OP_PROGRAM:    st_nxt = T_P1;
              OP_ADD_SECTOR: st_nxt = T_POST;
              default:       st_nxt = T_END;
            endcase
          end
        end
        T_PRE: begin
          if (cyc.rdata[WINDOW_BIT] || win_r == WIN_CYC) begin
            rej_nxt = 1'b1;
            st_nxt  = T_END;
          end else begin
            st_nxt = T_SEQ;
          end
        end
        T_POST: begin
          rej_nxt = cyc.rdata[WINDOW_BIT];
          st_nxt  = T_END;
        end
        T_P1: begin
          first_nxt = cyc.rdata;
          st_nxt    = T_P2;
        end
        T_P2: begin
          if (same) begin
            st_nxt = (op_r == OP_PROGRAM) ? T_VER : T_END;
          end else if (cyc.rdata[TIMEOUT_BIT]) begin
            st_nxt = T_P3;
          end else begin
            st_nxt = T_P1;
          end
        end
        T_P3: begin
          first_nxt = cyc.rdata;
          st_nxt    = T_P4;
        end
        T_P4: begin
          if (same) begin
            st_nxt = (op_r == OP_PROGRAM) ? T_VER : T_END;
          end else begin
            fail_nxt = 1'b1;
            op_nxt   = OP_RESET;
            st_nxt   = T_SEQ;
          end
        end
        T_VER: begin
          rdat_nxt = cyc.rdata;
          fail_nxt = (cyc.rdata != data_r);
          st_nxt   = T_END;
        end
        T_RDU: begin
          rdat_nxt = cyc.rdata;
          st_nxt   = T_END;
        end
        default: st_nxt = T_END;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      st_r    <= T_IDLE;
      op_r    <= OP_READ;
      addr_r  <= '0;
      data_r  <= '0;
      step_r  <= 3'h0;
      iss_r   <= 1'b0;
      req_r   <= 1'b0;
      cwr_r   <= 1'b0;
      cword_r <= '0;
      first_r <= '0;
      win_r   <= WIN_CYC;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
      fail_r  <= 1'b0;
      rej_r   <= 1'b0;
      rdat_r  <= '0;
      stat_r  <= '0;
    end else if (ce_i) begin
      st_r    <= st_nxt;
      op_r    <= op_nxt;
      addr_r  <= addr_nxt;
      data_r  <= data_nxt;
      step_r  <= step_nxt;
      iss_r   <= iss_nxt;
      req_r   <= req_nxt;
      cwr_r   <= cwr_nxt;
      cword_r <= cword_nxt;
      first_r <= first_nxt;
      win_r   <= win_nxt;
      busy_r  <= busy_nxt;
      done_r  <= done_nxt;
      fail_r  <= fail_nxt;
      rej_r   <= rej_nxt;
      rdat_r  <= rdat_nxt;
      stat_r  <= stat_nxt;
    end
  end

  assign cyc.req   = req_r;
  assign cyc.wr    = cwr_r;
  assign cyc.addr  = cword_r[SW-1:DATA_W];
  assign cyc.wdata = cword_r[DATA_W-1:0];

  assign busy_o     = busy_r;
  assign done_o     = done_r;
  assign fail_o     = fail_r;
  assign rejected_o = rej_r;
  assign rdata_o    = rdat_r;
  assign status_o   = stat_r;

endmodule

// >>> hdl/flash_host_pkg.sv
// Purpose: shared constants and types of the flash host controller
// Assumes: 40 MHz system clock, byte-wide asynchronous flash on the pins
// Notes:   pin timing is expressed in ns and converted to whole cycles
package flash_host_pkg;

  // ==========================================================
  // clock and pin timing
  localparam int CLK_NS      = 25;
  localparam int T_WE_NS     = 50;
  localparam int T_RD_NS     = 150;
  localparam int T_GAP_NS    = 25;
  localparam int T_GLITCH_NS = 5;
  localparam int T_WIN_NS    = 80000;
  localparam int SYNC_STAGES = 2;
  // least times round up
  localparam int WE_CYC  = (T_WE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC  = (T_RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W   = 4;

  // ==========================================================
  // bus widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;

  // ==========================================================
  // sector load window, a longest time: rounds down
  localparam int              WIN_W   = 12;
  localparam logic [WIN_W-1:0] WIN_CYC = WIN_W'(T_WIN_NS / CLK_NS);

  // ==========================================================
  // status byte fields
  localparam int POLL_BIT    = 7;
  localparam int TOGGLE1_BIT = 6;
  localparam int TIMEOUT_BIT = 5;
  localparam int WINDOW_BIT  = 3;
  localparam int TOGGLE2_BIT = 2;

  // ==========================================================
  // command codes
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP  = 8'h80;
  localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [DATA_W-1:0] CMD_PROGRAM      = 8'ha0;

  // ==========================================================
  // user operations
  typedef enum logic [2:0] {
    OP_READ, OP_PROGRAM, OP_ERASE, OP_ADD_SECTOR, OP_POLL, OP_RESET
  } op_t;

endpackage

// >>> hdl/flash_cyc_if.sv
// Purpose: one pin cycle request between sequencer and cycle engine
// Assumes: req is a one-cycle pulse, only while the engine is idle
// Notes:   ack pulses once when the cycle has ended on the pins
`timescale 1ns/10ps
interface flash_cyc_if;
  logic                              req;
  logic                              wr;
  logic [flash_host_pkg::ADDR_W-1:0] addr;
  logic [flash_host_pkg::DATA_W-1:0] wdata;
  logic                              ack;
  logic [flash_host_pkg::DATA_W-1:0] rdata;

  modport master (output req, wr, addr, wdata, input ack, rdata);
  modport engine (input req, wr, addr, wdata, output ack, rdata);
endinterface

// >>> hdl/flash_bus_cycle.sv
// Purpose: drives single read or write cycles on the flash pins
// Assumes: data pins arrive asynchronously and are synchronised here
// Notes:   chip select rises one cycle after the write strobe
`timescale 1ns/10ps
module flash_bus_cycle (
  input  wire logic                              clk_i,
  input  wire logic                              rst_n_i,
  input  wire logic                              en_i,
  flash_cyc_if.engine                            cyc,
  input  wire logic [flash_host_pkg::DATA_W-1:0] fl_dq_i,
  output logic      [flash_host_pkg::ADDR_W-1:0] fl_addr_o,
  output logic      [flash_host_pkg::DATA_W-1:0] fl_dq_o,
  output logic                                   fl_dq_oe_o,
  output logic                                   fl_ce_n_o,
  output logic                                   fl_oe_n_o,
  output logic                                   fl_we_n_o
);
  import flash_host_pkg::*;

  localparam logic [CNT_W-1:0] WE_LAST  = CNT_W'(WE_CYC - 1);
  localparam logic [CNT_W-1:0] RD_LAST  = CNT_W'(RD_CYC + SYNC_STAGES - 1);
  localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_CYC - 1);

  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} eng_st_t;

  eng_st_t           st_r,    st_nxt;
  logic [CNT_W-1:0]  cnt_r,   cnt_nxt;
  logic              wr_r,    wr_nxt;
  logic [ADDR_W-1:0] addr_r,  addr_nxt;
  logic [DATA_W-1:0] dq_r,    dq_nxt;
  logic              oe_r,    oe_nxt;
  logic              ce_n_r,  ce_n_nxt;
  logic              oe_n_r,  oe_n_nxt;
  logic              we_n_r,  we_n_nxt;
  logic              ack_r,   ack_nxt;
  logic [DATA_W-1:0] rdat_r,  rdat_nxt;
  logic [DATA_W-1:0] dq_s1_r;
  logic [DATA_W-1:0] dq_s2_r;

  // ==========================================================
  // cycle sequencing
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    wr_nxt   = wr_r;
    addr_nxt = addr_r;
    dq_nxt   = dq_r;
    oe_nxt   = oe_r;
    ce_n_nxt = ce_n_r;
    oe_n_nxt = oe_n_r;
    we_n_nxt = we_n_r;
    ack_nxt  = 1'b0;
    rdat_nxt = rdat_r;
    unique case (st_r)
      E_IDLE: begin
        if (cyc.req) begin
          wr_nxt   = cyc.wr;
          addr_nxt = cyc.addr;
          dq_nxt   = cyc.wdata;
          ce_n_nxt = 1'b0;
          oe_n_nxt = cyc.wr;
          oe_nxt   = cyc.wr;
          if (cyc.wr) begin
            st_nxt = E_SETUP;
          end else begin
            st_nxt  = E_STROBE;
            cnt_nxt = RD_LAST;
          end
        end
      end
      E_SETUP: begin
        we_n_nxt = 1'b0;
        cnt_nxt  = WE_LAST;
        st_nxt   = E_STROBE;
      end
      E_STROBE: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else begin
          if (!wr_r) begin
            rdat_nxt = dq_s2_r;
          end
          we_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          cnt_nxt  = GAP_LAST;
          st_nxt   = E_HOLD;
        end
      end
      E_HOLD: begin
        ce_n_nxt = 1'b1;
        oe_nxt   = 1'b0;
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else begin
          ack_nxt = 1'b1;
          st_nxt  = E_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r    <= E_IDLE;
      cnt_r   <= '0;
      wr_r    <= 1'b0;
      addr_r  <= '0;
      dq_r    <= '0;
      oe_r    <= 1'b0;
      ce_n_r  <= 1'b1;
      oe_n_r  <= 1'b1;
      we_n_r  <= 1'b1;
      ack_r   <= 1'b0;
      rdat_r  <= '0;
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else if (en_i) begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      wr_r    <= wr_nxt;
      addr_r  <= addr_nxt;
      dq_r    <= dq_nxt;
      oe_r    <= oe_nxt;
      ce_n_r  <= ce_n_nxt;
      oe_n_r  <= oe_n_nxt;
      we_n_r  <= we_n_nxt;
      ack_r   <= ack_nxt;
      rdat_r  <= rdat_nxt;
      dq_s1_r <= fl_dq_i;
      dq_s2_r <= dq_s1_r;
    end
  end

  assign cyc.ack    = ack_r;
  assign cyc.rdata  = rdat_r;
  assign fl_addr_o  = addr_r;
  assign fl_dq_o    = dq_r;
  assign fl_dq_oe_o = oe_r;
  assign fl_ce_n_o  = ce_n_r;
  assign fl_oe_n_o  = oe_n_r;
  assign fl_we_n_o  = we_n_r;

endmodule

// >>> verif/flash_host_ctrl_props.sv
// Purpose: port checker of the flash host controller
// Assumes: one clock domain, ports of the top module only
// Notes:   bound into every flash_host_ctrl instance
`timescale 1ns/10ps
module flash_host_ctrl_props (
  input wire logic                              clk_sys_i,
  input wire logic                              nrst_i,
  input wire logic                              ce_i,
  input wire logic                              cmd_valid_i,
  input wire logic                              busy_o,
  input wire logic                              done_o,
  input wire logic                              fail_o,
  input wire logic                              rejected_o,
  input wire logic [flash_host_pkg::ADDR_W-1:0] fl_addr_o,
  input wire logic [flash_host_pkg::DATA_W-1:0] fl_dq_o,
  input wire logic                              fl_dq_oe_o,
  input wire logic                              fl_ce_n_o,
  input wire logic                              fl_oe_n_o,
  input wire logic                              fl_we_n_o
);
  import flash_host_pkg::*;
  // ==========================================================
  // pin cycle shape, order handshake and result flags
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  a_write_inhibit: assert property (
    !fl_we_n_o |-> !fl_ce_n_o && fl_oe_n_o)
    else $error("write strobe outside a selected write cycle");
  a_we_width: assert property (
    $fell(fl_we_n_o) |-> (!fl_we_n_o && fl_dq_oe_o)[*2] ##1 fl_we_n_o)
    else $error("write strobe not two cycles long");
  a_data_hold: assert property (
    $rose(fl_we_n_o) |-> $stable(fl_addr_o) && $stable(fl_dq_o) && fl_dq_oe_o)
    else $error("address or data moved under the write strobe");
  a_ce_after_we: assert property (
    $rose(fl_we_n_o) |=> $rose(fl_ce_n_o))
    else $error("select did not rise one cycle after the strobe");
  a_read_pulse: assert property (
    $fell(fl_oe_n_o) |-> (!fl_oe_n_o && !fl_ce_n_o && fl_we_n_o)[*8]
      ##1 (fl_oe_n_o && !fl_ce_n_o) ##1 fl_ce_n_o)
    else $error("read cycle not eight cycles long");
  a_dq_no_clash: assert property (
    fl_dq_oe_o |-> fl_oe_n_o)
    else $error("data driven while output enable low");
  a_idle_pins: assert property (
    !busy_o |-> fl_ce_n_o && fl_oe_n_o && fl_we_n_o && !fl_dq_oe_o)
    else $error("pin activity while idle");
  a_done_pulse: assert property (
    done_o |-> !busy_o && $past(busy_o) ##1 !done_o)
    else $error("done not a single pulse ending busy");
  a_order_taken: assert property (
    cmd_valid_i && ce_i && !busy_o |=> busy_o)
    else $error("order not taken while idle");
  a_result_stands: assert property (
    !busy_o && !done_o |-> $stable(fail_o) && $stable(rejected_o))
    else $error("result flags changed while idle");
  c_fail: cover property (done_o && fail_o);
  c_reject: cover property (done_o && rejected_o);
  c_pass: cover property (done_o && !fail_o && !rejected_o);
endmodule

bind flash_host_ctrl flash_host_ctrl_props i_flash_host_ctrl_props (
  .clk_sys_i, .nrst_i, .ce_i, .cmd_valid_i, .busy_o, .done_o, .fail_o,
  .rejected_o, .fl_addr_o, .fl_dq_o, .fl_dq_oe_o, .fl_ce_n_o, .fl_oe_n_o,
  .fl_we_n_o
);

// >>> verif/flash_dev_model.sv
// Purpose: behavioural flash device on the host controller's pins
// Assumes: no clock; cycles framed by select, output enable and strobe
// Notes:   busy phases end after counted reads, elapsed time or a reset write
`timescale 1ns/10ps
module flash_dev_model #(
  parameter logic [3:0] PROT_SECT   = 4'hf,
  parameter int         PROG_READS  = 3,
  parameter int         LOCK_READS  = 6,
  parameter int         ERASE_READS = 4
) (
  input  wire logic [19:0] addr_i,
  input  wire logic [7:0]  dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  output logic      [7:0]  dq_o = 8'h00
);
  logic [7:0]  mem [256];
  logic [15:0] sect_sel = '0;
  logic [7:0]  pdata = '0;
  logic [7:0]  st;
  logic [7:0]  pa;
  logic [2:0]  step = '0;
  logic        busy = 0, erase = 0, prot = 0, locked = 0, ok;
  logic        tog1 = 0, tog2 = 0, tout = 0;
  int          left = 0, writes = 0;
  realtime     t_fall = 0, t_win = 0;
  wire         rd_n = ce_n_i | oe_n_i;
  wire         wr_n = ce_n_i | we_n_i | ~oe_n_i;
  // ==========================================================
  // power-up: array read mode over an erased array
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
  end
  task automatic finish_op();
    if (erase) begin
      for (int i = 0; i < 256; i++)
        if (sect_sel[i[7:4]] && i[7:4] != PROT_SECT)
          mem[i] = 8'hff;
    end else
      mem[pa] = pdata;
    {busy, erase, sect_sel} = '0;
  endtask
  // ==========================================================
  // reads: status while busy, inverted last value once released
  always @(negedge rd_n or addr_i) begin
    if (!rd_n) begin
      st = 8'h00;
      st[7] = erase ? 1'b0 : ~pdata[7];
      st[6] = tog1;
      st[5] = tout;
      st[3] = erase && ($realtime - t_win >= 80000.0);
      st[2] = sect_sel[addr_i[19:16]] ? tog2 : 1'b1;
      dq_o = busy ? st : mem[{addr_i[19:16], addr_i[3:0]}];
    end
  end
  always @(posedge rd_n) begin
    dq_o = ~dq_o;
    if (busy) begin
      tog1 = ~tog1;
      if (sect_sel[addr_i[19:16]])
        tog2 = ~tog2;
      if (prot) begin
        if ($realtime - t_win >= 2000.0)
          busy = 0;
      end else if (!erase || $realtime - t_win >= 80000.0) begin
        if (left > 0)
          left--;
        else if (locked)
          tout = 1;
        else
          finish_op();
      end
    end
  end
  // ==========================================================
  // writes and command sequences
  always @(negedge wr_n) t_fall = $realtime;
  always @(posedge wr_n) begin
    if ($realtime - t_fall >= 5.0) begin
      writes++;
      if (dq_i == 8'hf0 && (!busy || tout)) begin
        {busy, erase, prot, locked, tout, step, sect_sel} = '0;
      end else if (busy) begin
        if (erase && dq_i == 8'h30 && $realtime - t_win < 80000.0) begin
          sect_sel[addr_i[19:16]] = 1'b1;
          t_win = $realtime;
        end
      end else begin
        case (step)
          3'd0, 3'd4: ok = addr_i == 20'h00555 && dq_i == 8'haa;
          3'd1, 3'd5: ok = addr_i == 20'h002aa && dq_i == 8'h55;
          3'd2: ok = addr_i == 20'h00555 && (dq_i == 8'ha0 || dq_i == 8'h80);
          3'd6: ok = dq_i == 8'h30;
          default: ok = 1'b1;
        endcase
        if (!ok)
          step = 0;
        else if (step == 3'd2)
          step = dq_i == 8'ha0 ? 3'd3 : 3'd4;
        else if (step == 3'd3 || step == 3'd6) begin
          erase = step == 3'd6;
          pdata = dq_i;
          pa = {addr_i[19:16], addr_i[3:0]};
          prot = !erase && addr_i[19:16] == PROT_SECT;
          locked = !erase && mem[pa] != 8'hff;
          sect_sel = erase ? 16'h1 << addr_i[19:16] : 16'h0;
          left = erase ? ERASE_READS : locked ? LOCK_READS : PROG_READS;
          t_win = $realtime;
          busy = 1'b1;
          step = 0;
        end else
          step = step + 3'd1;
      end
    end
  end
endmodule

// >>> verif/test_flash_host_ctrl.sv
// Purpose: self-checking bench of the flash host controller
// Assumes: behavioural flash device on the pins, clock enable held high
// Notes:   each scenario is one task that judges its own results
`timescale 1ns/10ps
module test_flash_host_ctrl;
  import flash_host_pkg::*;
  logic              clk_sys_i, nrst_i, ce_i, cmd_valid_i;
  op_t               cmd_i;
  logic [ADDR_W-1:0] cmd_addr_i, fl_addr_o;
  logic [DATA_W-1:0] cmd_data_i, rdata_o, status_o, fl_dq_o, dev_q;
  logic              busy_o, done_o, fail_o, rejected_o;
  logic              fl_dq_oe_o, fl_ce_n_o, fl_oe_n_o, fl_we_n_o;
  int                fails = 0, tests_run = 0, w0;
  wire logic [DATA_W-1:0] dq_w = fl_dq_oe_o ? fl_dq_o : dev_q;
  flash_host_ctrl i_flash_host_ctrl (
    .clk_sys_i, .nrst_i, .ce_i, .cmd_valid_i, .cmd_i, .cmd_addr_i,
    .cmd_data_i, .busy_o, .done_o, .fail_o, .rejected_o, .rdata_o,
    .status_o, .fl_dq_i(dq_w), .fl_addr_o, .fl_dq_o, .fl_dq_oe_o,
    .fl_ce_n_o, .fl_oe_n_o, .fl_we_n_o
  );
  flash_dev_model i_flash_dev_model (
    .addr_i(fl_addr_o), .dq_i(dq_w), .ce_n_i(fl_ce_n_o),
    .oe_n_i(fl_oe_n_o), .we_n_i(fl_we_n_o), .dq_o(dev_q)
  );
  // ==========================================================
  // compare and order helpers
  task automatic chk_bit(string what, logic e, logic g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic chk_byte(string what, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic order(op_t op, logic [19:0] a, logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i) #2;
    cmd_valid_i = 1'b1;
    cmd_i = op;
    cmd_addr_i = a;
    cmd_data_i = d;
    @(posedge clk_sys_i) #2;
    cmd_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 20000) begin
      @(posedge clk_sys_i) #2;
      n++;
    end
    chk_bit("done", 1'b1, done_o);
  endtask
  task automatic results();
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_power_up();
    chk_bit("strobes idle", 1'b1, fl_ce_n_o & fl_oe_n_o & fl_we_n_o);
    order(OP_READ, 20'h12345, 8'h00);
    chk_byte("blank read", 8'hff, rdata_o);
  endtask
  task automatic t_program();
    order(OP_PROGRAM, 20'h12345, 8'h5a);
    chk_bit("program fail", 1'b0, fail_o);
    order(OP_PROGRAM, 20'h20001, 8'h3c);
    order(OP_READ, 20'h12345, 8'h00);
    chk_byte("programmed byte", 8'h5a, rdata_o);
  endtask
  task automatic t_non_blank();
    order(OP_PROGRAM, 20'h12345, 8'h00);
    chk_bit("locked fail", 1'b1, fail_o);
    chk_bit("device busy", 1'b0, i_flash_dev_model.busy);
    order(OP_READ, 20'h12345, 8'h00);
    chk_byte("byte kept", 8'h5a, rdata_o);
  endtask
  task automatic t_protected();
    order(OP_PROGRAM, 20'hf0010, 8'h00);
    chk_bit("protected fail", 1'b1, fail_o);
    order(OP_READ, 20'hf0010, 8'h00);
    chk_byte("protected byte", 8'hff, rdata_o);
    order(OP_RESET, 20'h00000, 8'h00);
    chk_bit("reset fail", 1'b0, fail_o);
  endtask
  task automatic t_erase_add();
    order(OP_ERASE, 20'h10000, 8'h00);
    order(OP_ADD_SECTOR, 20'h20000, 8'h00);
    chk_bit("add refused", 1'b0, rejected_o);
    chk_bit("window bit", 1'b0, status_o[WINDOW_BIT]);
    order(OP_POLL, 20'h10000, 8'h00);
    chk_bit("erase fail", 1'b0, fail_o);
    order(OP_READ, 20'h12345, 8'h00);
    chk_byte("first sector", 8'hff, rdata_o);
    order(OP_READ, 20'h20001, 8'h00);
    chk_byte("added sector", 8'hff, rdata_o);
  endtask
  task automatic t_late_add();
    order(OP_ERASE, 20'h30000, 8'h00);
    repeat (3300) @(posedge clk_sys_i);
    w0 = i_flash_dev_model.writes;
    order(OP_ADD_SECTOR, 20'h40000, 8'h00);
    chk_bit("late add refused", 1'b1, rejected_o);
    chk_bit("no late write", 1'b1, w0 == i_flash_dev_model.writes);
    order(OP_POLL, 20'h30000, 8'h00);
    chk_bit("late erase fail", 1'b0, fail_o);
  endtask
  // ==========================================================
  // clock, watchdog and main sequence
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    // scenarios need about 7000 cycles; allow well over twice that
    #(25 * 40000);
    fails++;
    results();
  end
  initial begin
    {nrst_i, ce_i, cmd_valid_i} = 3'b010;
    cmd_i = OP_READ;
    cmd_addr_i = '0;
    cmd_data_i = '0;
    repeat (8) @(posedge clk_sys_i);
    #2 nrst_i = 1'b1;
    repeat (3) @(posedge clk_sys_i) #2;
    t_power_up();
    t_program();
    t_non_blank();
    t_protected();
    t_erase_add();
    t_late_add();
    results();
  end
endmodule
